// ### logic/slc_config_bank.sv
// configuration register bank for the serial output link and bank 5 trims
`timescale 1ns/100ps
`include "slc_regs.svh"

// Notes on behaviour
// RULE1: bank 5 phase-0 trim, 8-bit read/write, applied only in zero-degree phase.
// RULE2: bank 5 phase-90 trim, 8-bit read/write, applied only in minus-ninety phase.
// RULE3: trims load factory value at reset, read back and overwritable.
// RULE4: stamp enable bit replaces each output sample LSB with timestamp.
// RULE5: timestamp beats calibration-state when both insertions are enabled.
// RULE6: software must also set the stamp receiver enable bit.
// RULE7: stamp bit delayed by same latency as the samples it marks.
// RULE8: control-bit count advertised in lane alignment sequence stays zero.
// RULE9: link enable bit 0 resets to 1; 0 disables, 1 enables.
// RULE10: software clears link enable before changing other link registers.
// RULE11: link disabled holds link logic in reset, serializers down, clocks gated.
// RULE12: link disabled holds multiframe counter in reset, ignoring SYSREF.
// RULE13: software sets calibration enable before link enable, clears in reverse.
// RULE14: 5-bit output mode resets to 2; change only with link and cal off.
module slc_config_bank (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// host register port
	input wire slc_pkg::slc_req_type i_req,
	output logic [7:0] o_rdata,
	// factory trim values captured after reset
	input wire logic [7:0] i_fuse_trim_p0,
	input wire logic [7:0] i_fuse_trim_p90,
	// calibration enable from the calibration block
	input wire logic i_cal_en,
	// timestamp pin, asynchronous
	input wire logic i_stamp_pin,
	// sample stream from the converter core
	input wire slc_pkg::slc_sample_type i_sample,
	output slc_pkg::slc_sample_type o_sample,
	// trim applied to bank 5
	output logic [7:0] o_bank5_trim,
	// link control outputs
	output logic o_link_rst,
	output logic o_ser_pwrdn,
	output logic o_link_clk_en,
	output logic o_lmfc_rst,
	output logic o_lmfc_align,
	output logic [4:0] o_out_mode,
	output logic [4:0] o_ila_cs,
	output logic o_mode_viol,
	// multiframe alignment event
	input wire logic i_sysref
);
	import slc_pkg::*;

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] trim_p0_r;
	logic [7:0] trim_p90_r;
	logic [7:0] lsb_ctrl_r;
	logic [7:0] link_en_r;
	logic [7:0] out_mode_r;
	logic [7:0] km1_r;
	logic [7:0] sync_req_r;
	logic [7:0] link_ctrl_r;
	logic [7:0] test_pat_r;
	logic [7:0] dev_id_r;
	logic [7:0] frame_character_select_r;
	logic [7:0] channel_power_down_r;
	logic [7:0] extra_a_r;
	logic [7:0] extra_b_r;
	logic [7:0] aux_ctrl_r;
	logic fuse_load_r;
	logic mode_viol_r;
	logic [7:0] rdata_nxt;
	logic link_on;
	logic wr_mode;

	assign link_on = link_en_r[`SLC_BIT_LINK_EN];
	assign wr_mode = i_req.wr && (i_req.addr == `SLC_ADDR_OUT_MODE);

	// ****************************************
	// trim registers
	// ****************************************
	// fuse values are sampled by a clocked load after release, never under reset
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			fuse_load_r <= 1'b1;
			trim_p0_r <= `SLC_RST_ZERO;
			trim_p90_r <= `SLC_RST_ZERO;
		end else if (fuse_load_r) begin
			fuse_load_r <= 1'b0;
			trim_p0_r <= i_fuse_trim_p0; // RULE3
			trim_p90_r <= i_fuse_trim_p90; // RULE3
		end else if (i_req.wr) begin
			if (i_req.addr == `SLC_ADDR_TRIM_P0) begin
				trim_p0_r <= i_req.wdata; // RULE1
			end
			if (i_req.addr == `SLC_ADDR_TRIM_P90) begin
				trim_p90_r <= i_req.wdata; // RULE2
			end
		end
	end

	// trim applied follows the selected clock phase
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_bank5_trim <= `SLC_RST_ZERO;
		end else if (aux_ctrl_r[`SLC_BIT_PHASE90]) begin
			o_bank5_trim <= trim_p90_r; // RULE2
		end else begin
			o_bank5_trim <= trim_p0_r; // RULE1
		end
	end

	// ****************************************
	// link and control registers
	// ****************************************
	// plain read/write storage; reserved bits are kept as written
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			lsb_ctrl_r <= `SLC_RST_LSB_CTRL; // RULE4
			link_en_r <= `SLC_RST_LINK_EN; // RULE9
			km1_r <= `SLC_RST_KM1;
			sync_req_r <= `SLC_RST_SYNC_REQ;
			link_ctrl_r <= `SLC_RST_LINK_CTRL;
			test_pat_r <= `SLC_RST_ZERO;
			dev_id_r <= `SLC_RST_ZERO;
			frame_character_select_r <= `SLC_RST_ZERO;
			channel_power_down_r <= `SLC_RST_ZERO;
			extra_a_r <= `SLC_RST_ZERO;
			extra_b_r <= `SLC_RST_ZERO;
			aux_ctrl_r <= `SLC_RST_AUX_CTRL;
		end else if (i_req.wr) begin
			unique case (i_req.addr)
				`SLC_ADDR_LSB_CTRL: lsb_ctrl_r <= i_req.wdata;
				`SLC_ADDR_LINK_EN: link_en_r <= i_req.wdata; // RULE9
				`SLC_ADDR_KM1: km1_r <= i_req.wdata;
				`SLC_ADDR_SYNC_REQ: sync_req_r <= i_req.wdata;
				`SLC_ADDR_LINK_CTRL: link_ctrl_r <= i_req.wdata;
				`SLC_ADDR_TEST_PAT: test_pat_r <= i_req.wdata;
				`SLC_ADDR_DEV_ID: dev_id_r <= i_req.wdata;
				`SLC_ADDR_FRAME_CHARACTER_SELECT: frame_character_select_r <= i_req.wdata;
				`SLC_ADDR_CHANNEL_POWER_DOWN: channel_power_down_r <= i_req.wdata;
				`SLC_ADDR_EXTRA_A: extra_a_r <= i_req.wdata;
				`SLC_ADDR_EXTRA_B: extra_b_r <= i_req.wdata;
				`SLC_ADDR_AUX_CTRL: aux_ctrl_r <= i_req.wdata;
				default: ;
			endcase
		end
	end

	// output mode: stored even if written out of order, but flagged
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			out_mode_r <= `SLC_RST_OUT_MODE; // RULE14
		end else if (wr_mode) begin
			out_mode_r <= i_req.wdata; // RULE14
		end
	end

	// sticky flag: mode written while link or calibration was running
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			mode_viol_r <= 1'b0;
		end else if (wr_mode && (link_on || i_cal_en)) begin
			mode_viol_r <= 1'b1; // RULE14
		end else if (i_req.wr && i_req.addr == `SLC_ADDR_STATUS) begin
			mode_viol_r <= 1'b0;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	always_comb begin
		rdata_nxt = 8'h00;
		unique case (i_req.addr)
			`SLC_ADDR_TRIM_P0: rdata_nxt = trim_p0_r; // RULE3
			`SLC_ADDR_TRIM_P90: rdata_nxt = trim_p90_r;
			`SLC_ADDR_LSB_CTRL: rdata_nxt = lsb_ctrl_r;
			`SLC_ADDR_LINK_EN: rdata_nxt = link_en_r;
			`SLC_ADDR_OUT_MODE: rdata_nxt = out_mode_r;
			`SLC_ADDR_KM1: rdata_nxt = km1_r;
			`SLC_ADDR_SYNC_REQ: rdata_nxt = sync_req_r;
			`SLC_ADDR_LINK_CTRL: rdata_nxt = link_ctrl_r;
			`SLC_ADDR_TEST_PAT: rdata_nxt = test_pat_r;
			`SLC_ADDR_DEV_ID: rdata_nxt = dev_id_r;
			`SLC_ADDR_FRAME_CHARACTER_SELECT: rdata_nxt = frame_character_select_r;
			`SLC_ADDR_STATUS: rdata_nxt = {6'h00, mode_viol_r, link_on};
			`SLC_ADDR_CHANNEL_POWER_DOWN: rdata_nxt = channel_power_down_r;
			`SLC_ADDR_EXTRA_A: rdata_nxt = extra_a_r;
			`SLC_ADDR_EXTRA_B: rdata_nxt = extra_b_r;
			`SLC_ADDR_AUX_CTRL: rdata_nxt = aux_ctrl_r;
			default: rdata_nxt = 8'h00; // unmapped reads zero
		endcase
	end

	// data stand only in the cycle after the read strobe
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_rdata <= 8'h00;
		end else if (i_req.rd) begin
			o_rdata <= rdata_nxt;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// ****************************************
	// link control outputs
	// ****************************************
	// a disabled link is held in reset with clocks gated to save power
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_link_rst <= 1'b1;
			o_ser_pwrdn <= 1'b1;
			o_link_clk_en <= 1'b0;
			o_lmfc_rst <= 1'b1;
			o_lmfc_align <= 1'b0;
			o_out_mode <= 5'h02;
			o_ila_cs <= 5'h00;
			o_mode_viol <= 1'b0;
		end else begin
			o_link_rst <= !link_on; // RULE11
			o_ser_pwrdn <= !link_on; // RULE11
			o_link_clk_en <= link_on; // RULE11
			o_lmfc_rst <= !link_on; // RULE12
			o_lmfc_align <= link_on && i_sysref; // RULE12
			o_out_mode <= out_mode_r[`SLC_MODE_MSB:0];
			o_ila_cs <= 5'h00; // RULE8
			o_mode_viol <= mode_viol_r;
		end
	end

	// ****************************************
	// timestamp insertion
	// ****************************************
	// pin synchroniser; first stage feeds only the second
	logic stamp_s1_r;
	logic stamp_s2_r;
	logic stamp_gate;
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			stamp_s1_r <= 1'b0;
			stamp_s2_r <= 1'b0;
		end else begin
			stamp_s1_r <= i_stamp_pin;
			stamp_s2_r <= stamp_s1_r;
		end
	end
	// receiver enable gates the pin; software must set it with the stamp enable
	assign stamp_gate = stamp_s2_r && aux_ctrl_r[`SLC_BIT_STAMP_RX_EN]; // RULE6

	// stamp and sample travel the same pipeline so latency matches
	slc_sample_type pipe_r [`SLC_PIPE_LAT];
	slc_sample_type stage_in;
	slc_sample_type last;
	always_comb begin
		stage_in = i_sample;
		stage_in.stamp = stamp_gate; // RULE7
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			for (int i = 0; i < `SLC_PIPE_LAT; i++) begin
				pipe_r[i] <= '0;
			end
		end else begin
			pipe_r[0] <= stage_in; // RULE7
			for (int i = 1; i < `SLC_PIPE_LAT; i++) begin
				pipe_r[i] <= pipe_r[i-1]; // RULE7
			end
		end
	end

	assign last = pipe_r[`SLC_PIPE_LAT-1];

	// lsb substitution: timestamp wins over calibration state
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_sample <= '0;
		end else begin
			o_sample <= last;
			if (lsb_ctrl_r[`SLC_BIT_STAMP_EN]) begin
				o_sample.data[0] <= last.stamp; // RULE4 RULE5
			end else if (aux_ctrl_r[`SLC_BIT_CALSTATE_EN]) begin
				o_sample.data[0] <= last.cal_state;
			end
		end
	end

endmodule : slc_config_bank

// ### shared/slc_regs.svh
// register offsets, field positions, reset values and timing counts of the link config bank
`ifndef SLC_REGS_SVH
`define SLC_REGS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SLC_ADDR_TRIM_P0      12'h152
`define SLC_ADDR_TRIM_P90     12'h153
`define SLC_ADDR_LSB_CTRL     12'h160
`define SLC_ADDR_LINK_EN      12'h200
`define SLC_ADDR_OUT_MODE     12'h201
`define SLC_ADDR_KM1          12'h202
`define SLC_ADDR_SYNC_REQ     12'h203
`define SLC_ADDR_LINK_CTRL    12'h204
`define SLC_ADDR_TEST_PAT     12'h205
`define SLC_ADDR_DEV_ID       12'h206
`define SLC_ADDR_FRAME_CHARACTER_SELECT        12'h207
`define SLC_ADDR_STATUS       12'h208
`define SLC_ADDR_CHANNEL_POWER_DOWN        12'h209
`define SLC_ADDR_EXTRA_A      12'h20A
`define SLC_ADDR_EXTRA_B      12'h20B
`define SLC_ADDR_AUX_CTRL     12'h210

// ****************************************
// field positions
// ****************************************
`define SLC_BIT_STAMP_EN      0
`define SLC_BIT_LINK_EN       0
`define SLC_BIT_STAMP_RX_EN   0
`define SLC_BIT_CALSTATE_EN   1
`define SLC_BIT_PHASE90       2
`define SLC_MODE_MSB          4

// ****************************************
// reset values
// ****************************************
`define SLC_RST_LSB_CTRL      8'h00
`define SLC_RST_LINK_EN       8'h01
`define SLC_RST_OUT_MODE      8'h02
`define SLC_RST_KM1           8'h1F
`define SLC_RST_SYNC_REQ      8'h01
`define SLC_RST_LINK_CTRL     8'h02
`define SLC_RST_ZERO          8'h00
`define SLC_RST_AUX_CTRL      8'h00

// ****************************************
// timing counts
// ****************************************
`define SLC_PIPE_LAT          4

`endif

// ### shared/slc_pkg.sv
// types shared by the link configuration bank
package slc_pkg;

	// host register port request
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} slc_req_type;

	// sample stream with side bits
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic stamp;
		logic cal_state;
	} slc_sample_type;

endpackage : slc_pkg

// ### tb/slc_config_bank_asserts.sv
// port assertions for the link config bank
`timescale 1ns/100ps
`include "slc_regs.svh"
module slc_config_bank_asserts (
	// clock, reset, host port
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire slc_pkg::slc_req_type i_req,
	input wire logic [7:0] o_rdata,
	// samples and link controls
	input wire slc_pkg::slc_sample_type i_sample,
	input wire slc_pkg::slc_sample_type o_sample,
	input wire logic i_sysref,
	input wire logic o_link_rst,
	input wire logic o_ser_pwrdn,
	input wire logic o_link_clk_en,
	input wire logic o_lmfc_rst,
	input wire logic o_lmfc_align,
	input wire logic [4:0] o_out_mode,
	input wire logic [4:0] o_ila_cs
);
	import slc_pkg::*;
	// ********
	// one clock domain, so one default clocking
	// ********
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	wire en_wr = i_req.wr && i_req.addr == `SLC_ADDR_LINK_EN;
	// disabled link is fully parked, never half way
	property p_link_off;
		o_link_rst |-> o_ser_pwrdn && o_lmfc_rst && !o_link_clk_en;
	endproperty
	property p_ila_zero;
		o_ila_cs == 5'h00;
	endproperty
	property p_align;
		o_lmfc_align |-> $past(i_sysref) && !o_lmfc_rst;
	endproperty
	property p_dis_wr;
		en_wr && !i_req.wdata[0] |-> ##2 o_link_rst;
	endproperty
	property p_en_wr;
		en_wr && i_req.wdata[0] |-> ##2 o_link_clk_en && !o_lmfc_rst;
	endproperty
	property p_rd_idle;
		!i_req.rd |=> o_rdata == 8'h00;
	endproperty
	property p_mode_rd;
		i_req.rd && i_req.addr == `SLC_ADDR_OUT_MODE |=> o_rdata[4:0] == o_out_mode;
	endproperty
	// upper data bits travel untouched with the same delay
	property p_lat;
		i_sample.valid |-> ##5 o_sample.valid && o_sample.data[7:1] == $past(i_sample.data[7:1], 5);
	endproperty
	a_link_off: assert property (p_link_off) else $error("link parked state broken");
	a_ila_zero: assert property (p_ila_zero) else $error("control bit count not zero");
	a_align: assert property (p_align) else $error("alignment without cause");
	a_dis_wr: assert property (p_dis_wr) else $error("link not disabled");
	a_en_wr: assert property (p_en_wr) else $error("link not enabled");
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	a_mode_rd: assert property (p_mode_rd) else $error("mode readback differs");
	a_lat: assert property (p_lat) else $error("sample latency wrong");
	c_dis: cover property (en_wr && !i_req.wdata[0]);
	c_align: cover property (o_lmfc_align);
	c_samp: cover property (o_sample.valid);
endmodule : slc_config_bank_asserts

bind slc_config_bank slc_config_bank_asserts slc_config_bank_asserts_i (.i_clk_sys, .i_resetn,
	.i_req, .o_rdata, .i_sample, .o_sample, .i_sysref, .o_link_rst, .o_ser_pwrdn, .o_link_clk_en,
	.o_lmfc_rst, .o_lmfc_align, .o_out_mode, .o_ila_cs);

// ### tb/test_slc_config_bank.sv
// self-checking bench for the link config bank
`timescale 1ns/100ps
module test_slc_config_bank;
	import slc_pkg::*;
	// ********
	// stimulus, outputs and model state
	// ********
	logic i_clk_sys = 0, i_resetn = 0, i_cal_en = 0, i_stamp_pin = 0, i_sysref = 0;
	logic [7:0] i_fuse_trim_p0 = 8'h00, i_fuse_trim_p90 = 8'h00, o_rdata, o_bank5_trim;
	slc_req_type i_req = '0;
	slc_sample_type i_sample = '0, o_sample;
	logic [4:0] o_out_mode, o_ila_cs;
	logic o_link_rst, o_ser_pwrdn, o_link_clk_en, o_lmfc_rst, o_lmfc_align, o_mode_viol;
	logic [7:0] mdl[int], sv[32];
	logic pv[32], cv[32];
	logic [11:0] al[15] = '{12'h152, 12'h153, 12'h160, 12'h200, 12'h201, 12'h202, 12'h203,
		12'h204, 12'h205, 12'h206, 12'h207, 12'h209, 12'h20A, 12'h20B, 12'h210};
	int err_total = 0, n_tests = 0, cyc = 0;
	logic [31:0] seed = 32'h8DB7;
	slc_config_bank slc_config_bank_i (.i_clk_sys, .i_resetn, .i_req, .o_rdata, .i_fuse_trim_p0,
		.i_fuse_trim_p90, .i_cal_en, .i_stamp_pin, .i_sample, .o_sample, .o_bank5_trim,
		.o_link_rst, .o_ser_pwrdn, .o_link_clk_en, .o_lmfc_rst, .o_lmfc_align, .o_out_mode,
		.o_ila_cs, .o_mode_viol, .i_sysref);
	always #2.5 i_clk_sys = ~i_clk_sys;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// random sysref and a hang limit well above the run length
	always @(posedge i_clk_sys) begin
		i_sysref <= ^rnd();
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("unexpected at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk
	// ********
	// host port cycles, one idle cycle between strobes
	// ********
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_req <= '{a, d, 1'b1, 1'b0};
		@(posedge i_clk_sys);
		i_req.wr <= 1'b0;
		if (mdl.exists(a)) mdl[a] = d;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge i_clk_sys);
		i_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge i_clk_sys);
		i_req.rd <= 1'b0;
		#1 chk(o_rdata, mdl.exists(a) ? mdl[a] : 8'h00);
	endtask : rd
	// stamp pin leads its sample by two cycles through the sync flops
	task automatic stream(input logic st);
		logic [31:0] r;
		for (int k = 0; k < 29; k++) begin
			@(posedge i_clk_sys);
			r = rnd();
			sv[k] = r[7:0];
			pv[k] = r[8];
			cv[k] = r[9];
			i_sample <= '{k < 24, r[7:0], 1'b0, r[9]};
			i_stamp_pin <= r[8];
			#1 if (k >= 7) chk(o_sample.data, {sv[k-5][7:1], st ? pv[k-7] : cv[k-5]});
		end
	endtask : stream
	initial begin
		i_fuse_trim_p0 = 8'(rnd());
		i_fuse_trim_p90 = 8'(rnd());
		foreach (al[i]) mdl[al[i]] = 8'h00;
		mdl[12'h152] = i_fuse_trim_p0;
		mdl[12'h153] = i_fuse_trim_p90;
		mdl[12'h200] = 8'h01;
		mdl[12'h201] = 8'h02;
		mdl[12'h202] = 8'h1F;
		mdl[12'h203] = 8'h01;
		mdl[12'h204] = 8'h02;
		repeat (12) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		foreach (al[i]) rd(al[i]);
		rd(12'h161);
		wr(12'h200, 8'h00);
		@(posedge i_clk_sys);
		#1 chk(8'({o_link_rst, o_ser_pwrdn, o_lmfc_rst, o_link_clk_en}), 8'h0E);
		foreach (al[i]) wr(al[i], al[i] == 12'h200 ? 8'h00 : 8'(rnd()));
		wr(12'h161, 8'hFF);
		foreach (al[i]) rd(al[i]);
		rd(12'h161);
		wr(12'h210, 8'h00);
		@(posedge i_clk_sys);
		#1 chk(o_bank5_trim, mdl[12'h152]);
		wr(12'h210, 8'h04);
		@(posedge i_clk_sys);
		#1 chk(o_bank5_trim, mdl[12'h153]);
		wr(12'h201, 8'h1B);
		rd(12'h201);
		chk(8'(o_out_mode), 8'h1B);
		// receiver on and both insertions on, stamp must win
		wr(12'h210, 8'h03);
		wr(12'h160, 8'h01);
		stream(1'b1);
		wr(12'h160, 8'h00);
		stream(1'b0);
		// calibration on first, then a mode write out of order raises the sticky flag
		i_cal_en <= 1'b1;
		wr(12'h201, 8'h1B);
		@(posedge i_clk_sys);
		#1 chk(8'(o_mode_viol), 8'h01);
		wr(12'h208, 8'h00);
		@(posedge i_clk_sys);
		#1 chk(8'(o_mode_viol), 8'h00);
		wr(12'h200, 8'h01);
		repeat (20) @(posedge i_clk_sys);
		chk(8'(o_link_clk_en), 8'h01);
		chk(8'(o_lmfc_rst), 8'h00);
		wrap_up();
	end
endmodule : test_slc_config_bank
